// ### rtl/lrr_pkg.sv
/*
   shared constants, carriers and helpers for the light result readout:
   register offsets, field positions, result record and check code.
   assumes a single device clock and a synchronous active-high reset.
*/
package lrr_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_LIGHT_RESULT_HIGH    = 8'h00;
   localparam logic [7:0] REG_LIGHT_RESULT_LOW     = 8'h01;
   localparam logic [7:0] REG_HISTORY0_RESULT_HIGH = 8'h02;
   localparam logic [7:0] REG_HISTORY0_RESULT_LOW  = 8'h03;
   localparam logic [7:0] REG_HISTORY1_RESULT_HIGH = 8'h04;
   localparam logic [7:0] REG_HISTORY1_RESULT_LOW  = 8'h05;
   localparam logic [7:0] REG_HISTORY2_RESULT_HIGH = 8'h06;
   localparam logic [7:0] REG_HISTORY2_RESULT_LOW  = 8'h07;

   // -----------------------------------------------------------------
   // field positions and sizes
   // -----------------------------------------------------------------
   localparam int EXPONENT_LSB      = 12;
   localparam int MANT_HIGH_LSB     = 0;
   localparam int MANT_LOW_LSB      = 8;
   localparam int COUNT_LSB         = 4;
   localparam int CHECK_LSB         = 0;
   localparam int MANT_SPLIT        = 8;
   localparam int NUM_HISTORY       = 3;
   localparam int NUM_ENTRIES       = NUM_HISTORY + 1;

   // -----------------------------------------------------------------
   // reset values and identity
   // -----------------------------------------------------------------
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [3:0]  COUNT_RESET  = 4'h0;
   // target bus address: arbitrary value
   localparam logic [6:0]  TARGET_ADDR  = 7'h2a;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  exponent;
      logic [19:0] mantissa;
      logic [3:0]  count;
   } lrr_result_t;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] lrr_check(input lrr_result_t r);
      logic [3:0] x;
      x    = 4'h0;
      x[0] = ^{r.exponent, r.mantissa, r.count};
      x[1] = r.count[1] ^ r.count[3] ^ r.exponent[1] ^ r.exponent[3];
      for (int i = 1; i < 20; i += 2)
         x[1] = x[1] ^ r.mantissa[i];
      x[2] = r.count[3] ^ r.exponent[3] ^ r.mantissa[3] ^ r.mantissa[7]
           ^ r.mantissa[11] ^ r.mantissa[15] ^ r.mantissa[19];
      x[3] = r.mantissa[3] ^ r.mantissa[11] ^ r.mantissa[19];
      return x;
   endfunction

   function automatic logic [15:0] lrr_word(input lrr_result_t r,
                                            input logic        low);
      logic [15:0] w;
      w = 16'h0000;
      if (!low)
      begin
         w[EXPONENT_LSB +: 4]   = r.exponent;
         w[MANT_HIGH_LSB +: 12] = r.mantissa[19:MANT_SPLIT];
      end
      else
      begin
         w[MANT_LOW_LSB +: 8] = r.mantissa[MANT_SPLIT-1:0];
         w[COUNT_LSB +: 4]    = r.count;
         w[CHECK_LSB +: 4]    = lrr_check(r);
      end
      return w;
   endfunction

endpackage

// ### rtl/lrr_result_store.sv
/*
   result store: live result plus three older results, with a
   registered read port addressed by register offset.
   assumes conversion strobes come from logic on the same clock.
*/
module lrr_result_store
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        conv_done,
   input  wire logic [3:0]  conv_exponent,
   input  wire logic [19:0] conv_mantissa,
   input  wire logic [7:0]  read_addr,
   output logic      [15:0] read_data
);

   lrr_pkg::lrr_result_t entries      [lrr_pkg::NUM_ENTRIES];
   lrr_pkg::lrr_result_t next_entries [lrr_pkg::NUM_ENTRIES];
   logic [15:0]          next_read_data;

   // -----------------------------------------------------------------
   // capture and shift
   // -----------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < lrr_pkg::NUM_ENTRIES; i++)
         next_entries[i] = entries[i];
      if (conv_done)
      begin
         for (int i = 1; i < lrr_pkg::NUM_ENTRIES; i++)
            next_entries[i] = entries[i-1];
         next_entries[0].exponent = conv_exponent;
         next_entries[0].mantissa = conv_mantissa;
         next_entries[0].count    = entries[0].count + 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // read port
   // -----------------------------------------------------------------
   always_comb
   begin
      next_read_data = lrr_pkg::RESULT_RESET;
      if (read_addr <= lrr_pkg::REG_HISTORY2_RESULT_LOW)
         next_read_data = lrr_pkg::lrr_word(entries[read_addr[2:1]],
                                            read_addr[0]);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < lrr_pkg::NUM_ENTRIES; i++)
            entries[i] <= '0;
         read_data <= lrr_pkg::RESULT_RESET;
      end
      else
      begin
         for (int i = 0; i < lrr_pkg::NUM_ENTRIES; i++)
            entries[i] <= next_entries[i];
         read_data <= next_read_data;
      end
   end

endmodule // lrr_result_store

// ### rtl/lrr_readout.sv
/*
   light result readout: serial-bus target that serves the live and
   history result registers, read-only, high byte first.
   assumes scl and sda come from pins outside the clock domain and that
   the conversion front end pulses conv_done for one clock per result.
*/
module lrr_readout
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        burst_enable,
   input  wire logic        conv_done,
   input  wire logic [3:0]  conv_exponent,
   input  wire logic [19:0] conv_mantissa
);

   typedef enum {
      ST_IDLE,
      ST_RECV,
      ST_ACK_DRIVE,
      ST_ACK_END,
      ST_SEND,
      ST_HOST_ACK,
      ST_LOAD
   } lrr_state_t;

   typedef enum {
      PH_ADDR,
      PH_POINTER,
      PH_DATA
   } lrr_phase_t;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic scl_meta;
   logic scl_sync;
   logic scl_prev;
   logic sda_meta;
   logic sda_sync;
   logic sda_prev;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl_rise  = scl_sync & ~scl_prev;
   assign scl_fall  = ~scl_sync & scl_prev;
   assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

   // -----------------------------------------------------------------
   // result store
   // -----------------------------------------------------------------
   logic [7:0]  pointer;
   logic [15:0] reg_data;

   lrr_result_store u_store
   (
      .clock         (clock),
      .rst           (rst),
      .conv_done     (conv_done),
      .conv_exponent (conv_exponent),
      .conv_mantissa (conv_mantissa),
      .read_addr     (pointer),
      .read_data     (reg_data)
   );

   // -----------------------------------------------------------------
   // target state machine
   // -----------------------------------------------------------------
   lrr_state_t state;
   lrr_state_t next_state;
   lrr_phase_t phase;
   lrr_phase_t next_phase;
   logic [2:0] bit_count;
   logic [2:0] next_bit_count;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic       read_mode;
   logic       next_read_mode;
   logic       low_byte;
   logic       next_low_byte;
   logic [7:0] next_pointer;
   logic [7:0] base_pointer;
   logic [7:0] next_base_pointer;
   logic       drive;
   logic       next_drive;

   always_comb
   begin
      next_state        = state;
      next_phase        = phase;
      next_bit_count    = bit_count;
      next_shift        = shift;
      next_read_mode    = read_mode;
      next_low_byte     = low_byte;
      next_pointer      = pointer;
      next_base_pointer = base_pointer;
      next_drive        = drive;
      if (bus_stop)
      begin
         next_state   = ST_IDLE;
         next_drive   = 1'b0;
         next_pointer = base_pointer;
      end
      else if (bus_start)
      begin
         next_state     = ST_RECV;
         next_phase     = PH_ADDR;
         next_bit_count = 3'h0;
         next_low_byte  = 1'b0;
         next_drive     = 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               next_drive = 1'b0;
            end
            ST_RECV:
            begin
               if (scl_rise)
               begin
                  next_shift     = {shift[6:0], sda_sync};
                  next_bit_count = bit_count + 3'h1;
                  if (bit_count == 3'h7)
                     next_state = ST_ACK_DRIVE;
               end
            end
            ST_ACK_DRIVE:
            begin
               if (scl_fall)
               begin
                  next_drive = 1'b1;
                  next_state = ST_ACK_END;
                  case (phase)
                     PH_ADDR:
                     begin
                        next_read_mode = shift[0];
                        if (shift[7:1] != lrr_pkg::TARGET_ADDR)
                        begin
                           next_drive = 1'b0;
                           next_state = ST_IDLE;
                        end
                     end
                     PH_POINTER:
                     begin
                        next_pointer      = shift;
                        next_base_pointer = shift;
                     end
                     default:
                     begin
                        // data bytes are acknowledged, registers ignore
                        next_drive = 1'b1;
                     end
                  endcase
               end
            end
            ST_ACK_END:
            begin
               if (scl_fall)
               begin
                  next_drive     = 1'b0;
                  next_bit_count = 3'h0;
                  if (phase == PH_ADDR && read_mode)
                  begin
                     next_shift    = reg_data[15:8];
                     next_drive    = ~reg_data[15];
                     next_low_byte = 1'b0;
                     next_state    = ST_SEND;
                  end
                  else
                  begin
                     next_phase = (phase == PH_ADDR) ? PH_POINTER : PH_DATA;
                     next_state = ST_RECV;
                  end
               end
            end
            ST_SEND:
            begin
               if (scl_fall)
               begin
                  if (bit_count == 3'h7)
                  begin
                     next_drive = 1'b0;
                     next_state = ST_HOST_ACK;
                  end
                  else
                  begin
                     next_shift     = {shift[6:0], 1'b0};
                     next_drive     = ~shift[6];
                     next_bit_count = bit_count + 3'h1;
                  end
               end
            end
            ST_HOST_ACK:
            begin
               if (scl_rise)
               begin
                  if (sda_sync)
                     next_state = ST_IDLE;
                  else
                  begin
                     next_state    = ST_LOAD;
                     next_low_byte = ~low_byte;
                     if (low_byte && burst_enable)
                        next_pointer = pointer + 8'h01;
                  end
               end
            end
            ST_LOAD:
            begin
               if (scl_fall)
               begin
                  next_bit_count = 3'h0;
                  next_state     = ST_SEND;
                  if (low_byte)
                  begin
                     next_shift = reg_data[7:0];
                     next_drive = ~reg_data[7];
                  end
                  else
                  begin
                     next_shift = reg_data[15:8];
                     next_drive = ~reg_data[15];
                  end
               end
            end
            default:
            begin
               next_state = ST_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state        <= ST_IDLE;
         phase        <= PH_ADDR;
         bit_count    <= 3'h0;
         shift        <= 8'h00;
         read_mode    <= 1'b0;
         low_byte     <= 1'b0;
         pointer      <= lrr_pkg::REG_LIGHT_RESULT_HIGH;
         base_pointer <= lrr_pkg::REG_LIGHT_RESULT_HIGH;
         drive        <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         phase        <= next_phase;
         bit_count    <= next_bit_count;
         shift        <= next_shift;
         read_mode    <= next_read_mode;
         low_byte     <= next_low_byte;
         pointer      <= next_pointer;
         base_pointer <= next_base_pointer;
         drive        <= next_drive;
      end
   end

   // -----------------------------------------------------------------
   // open-drain data pin
   // -----------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe  = drive;

endmodule // lrr_readout

// ### tb/lrr_readout_monitor.sv
/*
   checker for the readout's bus pins: drive timing and idle behaviour.
   assumes it is bound to lrr_readout and sees only its ports.
*/
module lrr_readout_monitor
(
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // pin history
   // ----------------------------------------------------------------
   logic       scl_d;
   logic       sda_d;
   logic [5:0] fall_h;
   logic       fall;
   logic       bus_start;
   logic       bus_stop;

   assign fall      = scl_d & ~scl_in;
   assign bus_start = scl_d & scl_in & sda_d & ~sda_in;
   assign bus_stop  = scl_d & scl_in & ~sda_d & sda_in;

   always_ff @(posedge clock)
   begin
      scl_d  <= scl_in;
      sda_d  <= sda_in;
      fall_h <= {fall_h[4:0], fall};
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_drain_low; !sda_out; endproperty
   a_drain_low: assert property (p_drain_low)
      else $error("open-drain output not low");
   property p_reset_quiet; $fell(rst) |-> !sda_oe [*8]; endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("data pin driven right after reset");
   property p_edge_timing; $changed(sda_oe) |-> |fall_h[4:1]; endproperty
   a_edge_timing: assert property (p_edge_timing)
      else $error("data drive changed away from a clock fall");
   property p_quiet_high; scl_in [*6] |-> $stable(sda_oe); endproperty
   a_quiet_high: assert property (p_quiet_high)
      else $error("data drive changed while bus clock high");
   property p_stop_idle; bus_stop |=> !sda_oe [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("data pin driven after stop");
   property p_start_addr; bus_start |=> !sda_oe [*8]; endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("data pin driven during address");
   property p_bit_stands; $rose(sda_oe) |-> sda_oe [*8]; endproperty
   a_bit_stands: assert property (p_bit_stands)
      else $error("low bit too short");
   property p_rel_stands; $fell(sda_oe) |-> !sda_oe [*8]; endproperty
   a_rel_stands: assert property (p_rel_stands)
      else $error("released bit too short");
endmodule // lrr_readout_monitor

bind lrr_readout lrr_readout_monitor i_mon
(
   .clock   (clock),
   .rst     (rst),
   .scl_in  (scl_in),
   .sda_in  (sda_in),
   .sda_out (sda_out),
   .sda_oe  (sda_oe)
);

// ### tb/lrr_host_model.sv
/*
   bus controller model: start, stop, byte transfers, register reads.
   assumes the bench resolves the data wire with a pull-up.
*/
module lrr_host_model
(
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // bit and byte level
   // ----------------------------------------------------------------
   localparam int PH = 10;

   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic put_bit(input logic b);
      tick(1);
      sda_pull <= ~b;
      tick(PH);
      scl <= 1'b1;
      tick(PH);
      scl <= 1'b0;
   endtask

   task automatic get_bit(output logic b);
      tick(1);
      sda_pull <= 1'b0;
      tick(PH);
      scl <= 1'b1;
      tick(PH / 2);
      b = sda;
      tick(PH / 2);
      scl <= 1'b0;
   endtask

   task automatic start;
      tick(1);
      sda_pull <= 1'b1;
      tick(PH);
      scl <= 1'b0;
   endtask

   task automatic stop;
      tick(1);
      sda_pull <= 1'b1;
      tick(PH);
      scl <= 1'b1;
      tick(PH);
      sda_pull <= 1'b0;
      tick(PH);
   endtask

   task automatic send_byte(input logic [7:0] d, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(a);
      ok = ok & ~a;
   endtask

   task automatic recv_byte(output logic [7:0] d, input logic last);
      logic b;
      for (int i = 0; i < 8; i++)
      begin
         get_bit(b);
         d = {d[6:0], b};
      end
      put_bit(last);
   endtask

   // pointer write, then nd filler data bytes
   task automatic write_ptr(input logic [7:0] a, input logic [7:0] p,
                            input int nd, output logic ok);
      ok = 1'b1;
      start();
      send_byte(a, ok);
      send_byte(p, ok);
      repeat (nd) send_byte(8'hff, ok);
      stop();
   endtask

   task automatic read_regs(input logic [7:0] a, input int n,
                            output logic [15:0] w [8], output logic ok);
      logic [7:0] hi;
      logic [7:0] lo;
      ok = 1'b1;
      start();
      send_byte(a, ok);
      for (int i = 0; i < n; i++)
      begin
         recv_byte(hi, 1'b0);
         recv_byte(lo, i == n - 1);
         w[i] = {hi, lo};
      end
      stop();
   endtask
endmodule // lrr_host_model

// ### tb/tb.sv
/*
   testbench for the light result readout: conversions in, register
   reads over the serial bus through the controller model.
   assumes open-drain pins with a pull-up on the data wire.
*/
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // signals and helpers
   // ----------------------------------------------------------------
   localparam logic [7:0] WR = {lrr_pkg::TARGET_ADDR, 1'b0};
   localparam logic [7:0] RD = {lrr_pkg::TARGET_ADDR, 1'b1};
   logic                 clock;
   logic                 rst;
   logic                 scl;
   logic                 sda;
   logic                 sda_pull;
   logic                 sda_out;
   logic                 sda_oe;
   logic                 burst_enable;
   logic                 conv_done;
   logic [3:0]           conv_exponent;
   logic [19:0]          conv_mantissa;
   logic [15:0]          w [8];
   logic                 ok;
   int                   error_cnt;
   int                   total_checks;
   lrr_pkg::lrr_result_t hist [4];

   assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
   always #12.5 clock = ~clock;

   lrr_readout i_dut
   (
      .clock         (clock),
      .rst           (rst),
      .scl_in        (scl),
      .sda_in        (sda),
      .sda_out       (sda_out),
      .sda_oe        (sda_oe),
      .burst_enable  (burst_enable),
      .conv_done     (conv_done),
      .conv_exponent (conv_exponent),
      .conv_mantissa (conv_mantissa)
   );

   lrr_host_model i_host
   (
      .clock    (clock),
      .sda      (sda),
      .scl      (scl),
      .sda_pull (sda_pull)
   );

   function automatic logic [15:0] word_of(input lrr_pkg::lrr_result_t r,
                                           input logic low);
      logic [3:0] x;
      x[0] = ^{r.exponent, r.mantissa, r.count};
      x[1] = r.exponent[3] ^ r.exponent[1] ^ r.count[3] ^ r.count[1];
      x[2] = r.exponent[3] ^ r.count[3];
      x[3] = 1'b0;
      for (int i = 0; i < 20; i++)
      begin
         x[1] ^= (i % 2 == 1) & r.mantissa[i];
         x[2] ^= (i % 4 == 3) & r.mantissa[i];
         x[3] ^= (i % 8 == 3) & r.mantissa[i];
      end
      if (low)
         return {r.mantissa[7:0], r.count, x};
      return {r.exponent, r.mantissa[19:8]};
   endfunction

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic convert(input logic [3:0] e, input logic [19:0] m);
      @(posedge clock);
      conv_done     <= 1'b1;
      conv_exponent <= e;
      conv_mantissa <= m;
      @(posedge clock);
      conv_done <= 1'b0;
      for (int i = 3; i > 0; i--)
         hist[i] = hist[i - 1];
      hist[0] = {e, m, hist[0].count + 4'h1};
   endtask

   task automatic cmp_regs(input int p, input int n);
      int k;
      for (int i = 0; i < n; i++)
      begin
         k = p + i;
         check("register word", w[i], word_of(hist[k / 2], k % 2 == 1));
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      burst_enable <= 1'b1;
      i_host.write_ptr(WR, 8'h00, 0, ok);
      check("pointer ack", {15'h0, ok}, 16'h0001);
      i_host.read_regs(RD, 8, w, ok);
      check("ack", {15'h0, ok}, 16'h0001);
      cmp_regs(0, 8);
      $display("test reset done");
   endtask

   task automatic t_fields;
      convert(4'hf, 20'hfffff);
      convert(4'h8, 20'h80000);
      convert(4'h1, 20'h00008);
      convert(4'h5, 20'h5a5a5);
      i_host.read_regs(RD, 8, w, ok);
      cmp_regs(0, 8);
      $display("test fields done");
   endtask

   task automatic t_wrap;
      for (int i = 0; i < 16; i++)
         convert(4'(i), {4'(i), 16'h1234});
      burst_enable <= 1'b0;
      i_host.read_regs(RD, 2, w, ok);
      cmp_regs(0, 1);
      check("repeat word", w[1], word_of(hist[0], 1'b0));
      burst_enable <= 1'b1;
      i_host.write_ptr(WR, 8'h02, 0, ok);
      i_host.read_regs(RD, 2, w, ok);
      cmp_regs(2, 2);
      i_host.read_regs(RD, 1, w, ok);
      cmp_regs(2, 1);
      $display("test wrap done");
   endtask

   task automatic t_refuse;
      i_host.write_ptr(WR, 8'h00, 2, ok);
      check("data ack", {15'h0, ok}, 16'h0001);
      i_host.write_ptr(WR ^ 8'h02, 8'h05, 0, ok);
      check("foreign ack", {15'h0, ok}, 16'h0000);
      i_host.read_regs(RD, 2, w, ok);
      cmp_regs(0, 2);
      i_host.write_ptr(WR, lrr_pkg::REG_HISTORY2_RESULT_LOW, 0, ok);
      i_host.read_regs(RD, 2, w, ok);
      cmp_regs(7, 1);
      check("beyond map", w[1], lrr_pkg::RESULT_RESET);
      $display("test refuse done");
   endtask

   initial
   begin
      clock         = 1'b0;
      rst           = 1'b1;
      burst_enable  = 1'b0;
      conv_done     = 1'b0;
      conv_exponent = 4'h0;
      conv_mantissa = 20'h00000;
      error_cnt     = 0;
      total_checks  = 0;
      hist          = '{default: '0};
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_reset();
      t_fields();
      t_wrap();
      t_refuse();
      close_out();
   end

   initial
   begin
      repeat (90000) @(posedge clock);
      error_cnt++;
      close_out();
   end
endmodule // tb
